// *** core/dac_i2c_pkg.sv ***
// types shared by the dac i2c target
package dac_i2c_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_DATA_HI,
        ST_DATA_LO,
        ST_IGNORE
    } i2c_state_t;
    typedef logic [13:0] word_t;
    typedef logic [15:0][13:0] bank_t;
endpackage

// *** core/dac_i2c_regs.svh ***
// field codes, reset values and timing counts for the dac i2c target
`ifndef DAC_I2C_REGS_SVH
`define DAC_I2C_REGS_SVH
// =====================================================================
// variant and clock
`define CORE_CLK_MHZ    20
`define EIGHT_CH_VAR    1'b0
`define LAST_CH         4'hf
`define CH_A3_BIT       3
// =====================================================================
// bus framing
`define TGT_ADDR_HI     5'h15
`define BYTE_BITS       4'h8
`define PTR_BURST       8'hff
// =====================================================================
// register select and special function codes
`define RSEL_SFR        2'h0
`define RSEL_GAIN       2'h1
`define RSEL_OFFS       2'h2
`define RSEL_DATA       2'h3
`define CMD_NULL        6'h00
`define CMD_CLR_CODE    6'h01
`define CMD_SOFT_CLR    6'h02
`define CMD_PWR_DOWN    6'h08
`define CMD_PWR_UP      6'h09
`define CMD_MONITOR     6'h0a
`define CMD_CTRL        6'h0c
`define CMD_SOFT_RST    6'h0f
// =====================================================================
// reset values and fields
`define GAIN_RST        14'h3fff
`define OFFS_RST        14'h0000
`define DATA_RST        14'h0000
`define CTRL_RST        14'h2000
`define CR_PD_HIZ_BIT   13
`define CR_MON_EN_BIT   10
`define MON_SEL_HI      13
`define MON_SEL_LO      8
`define MON_HIZ_SEL     6'h3f
// =====================================================================
// timing, microseconds and derived cycles
`define SOFT_CLR_US_16  20
`define SOFT_CLR_US_8   15
`define PWR_UP_US       8
`define SOFT_RST_US     135
`define CLR_CYC_16      (`SOFT_CLR_US_16 * `CORE_CLK_MHZ)
`define CLR_CYC_8       (`SOFT_CLR_US_8 * `CORE_CLK_MHZ)
`define PWR_UP_CYC      (`PWR_UP_US * `CORE_CLK_MHZ)
`define SOFT_RST_CYC    (`SOFT_RST_US * `CORE_CLK_MHZ)
`endif

// *** core/dac_i2c_target.sv ***
// write-only i2c target and special function decoder of a multichannel dac
`timescale 1ns/1ps
`default_nettype none
`include "dac_i2c_regs.svh"

// Overview of operation
// - address, pointer, two data bytes; acked
// - pointer low bits select channel
// - no stop: new pointer plus data updates
// - stop ends repeated or burst sequence
// - register select bits pick channel register
// - pointer ff starts burst at channel zero
// - burst increments channel, then repeated mode
// - toggle mode barred during burst
// - select bits zero decode special commands
// - null command changes nothing, busy low
// - clear-code command stores payload, resets zero
// - clear pin or soft clear loads codes
// - soft clear holds busy low its time
// - soft power-down keeps all register contents
// - powered down amps hiz or ground load
// - power-up completes within eight microseconds
// - power-down is hardware or software
// - soft reset restores defaults within limit
// - monitor select from payload, 63 hiz
// - monitor routes channels or external inputs
// - monitor routes only when enabled
// - target address five fixed, two straps
// - ack every taken byte on ninth
module dac_i2c_target
    import dac_i2c_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_addr_strap_hi,
    input  wire logic       i_addr_strap_lo,
    input  wire logic       i_clear_n,
    input  wire logic       i_hw_pwr_down,
    output var  logic       o_sda_out,
    output var  logic       o_sda_oe_n,
    output var  bank_t      o_dac_code,
    output var  bank_t      o_gain,
    output var  bank_t      o_offset,
    output var  word_t      o_clear_code,
    output var  word_t      o_ctrl_reg,
    output var  logic       o_busy_n,
    output var  logic       o_pwr_down,
    output var  logic       o_amp_hiz,
    output var  logic       o_amp_gnd_load,
    output var  logic       o_amp_ready,
    output var  logic [5:0] o_mon_sel,
    output var  logic       o_mon_hiz,
    output var  logic       o_mon_route_en,
    output var  logic       o_toggle_allow
);
    localparam int PWRUP_BOUND = `PWR_UP_CYC + 3;

    // =================================================================
    // pin synchronisers and bus conditions
    logic [3:0] sync_s;
    logic       scl_s;
    logic       sda_s;
    logic       clr_s;
    logic       pd_s;
    logic       scl_d;
    logic       sda_d;
    logic       clr_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [1:0] strap_s;
    logic [1:0] strap_d;

    // reset levels match idle pins: power-down request idles low, so no false request
    line_sync #(.WIDTH(4)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_scl, i_sda, i_clear_n, i_hw_pwr_down}),
        .i_rst_val  (4'he),
        .o_sync     (sync_s)
    );
    line_sync #(.WIDTH(2)) u_strap (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_addr_strap_hi, i_addr_strap_lo}),
        .i_rst_val  (2'h3),
        .o_sync     (strap_s)
    );

    assign scl_s = sync_s[3];
    assign sda_s = sync_s[2];
    assign clr_s = sync_s[1];
    assign pd_s  = sync_s[0];

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            scl_d   <= 1'b1;
            sda_d   <= 1'b1;
            clr_d   <= 1'b1;
            strap_d <= 2'h0;
        end
        else
        begin
            scl_d   <= scl_s;
            sda_d   <= sda_s;
            clr_d   <= clr_s;
            strap_d <= strap_s;
        end
    end

    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

    // =================================================================
    // byte engine
    i2c_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic       ack_phase_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [7:0] hi_r;
    logic       burst_r;
    logic       commit_r;
    logic [7:0] cmd_ptr_r;
    word_t      cmd_word_r;
    logic [1:0] cmd_rsel_r;
    logic       byte_done;

    assign byte_done = scl_fall && !ack_phase_r && bit_cnt_r == `BYTE_BITS;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            ack_phase_r <= 1'b0;
            shift_r     <= 8'h00;
            ptr_r       <= 8'h00;
            hi_r        <= 8'h00;
            burst_r     <= 1'b0;
            commit_r    <= 1'b0;
            cmd_ptr_r   <= 8'h00;
            cmd_word_r  <= 14'h0000;
            cmd_rsel_r  <= 2'h0;
            o_sda_out   <= 1'b0;
            o_sda_oe_n  <= 1'b1;
        end
        else
        begin
            commit_r <= 1'b0;
            if (stop_det)
            begin
                // a half received word is simply dropped here
                state_r     <= ST_IDLE;
                burst_r     <= 1'b0;
                bit_cnt_r   <= 4'h0;
                ack_phase_r <= 1'b0;
                o_sda_oe_n  <= 1'b1;
            end
            else if (start_det)
            begin
                state_r     <= ST_ADDR;
                burst_r     <= 1'b0;
                bit_cnt_r   <= 4'h0;
                ack_phase_r <= 1'b0;
                o_sda_oe_n  <= 1'b1;
            end
            else if (scl_rise && !ack_phase_r && bit_cnt_r != `BYTE_BITS)
            begin
                shift_r   <= {shift_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (scl_fall && ack_phase_r)
            begin
                ack_phase_r <= 1'b0;
                bit_cnt_r   <= 4'h0;
                o_sda_oe_n  <= 1'b1;
            end
            else if (byte_done)
            begin
                ack_phase_r <= 1'b1;
                case (state_r)
                    ST_ADDR:
                    begin
                        if (shift_r == {`TGT_ADDR_HI, strap_d, 1'b0})
                        begin
                            state_r    <= ST_PTR;
                            o_sda_oe_n <= 1'b0;
                        end
                        else
                        begin
                            state_r <= ST_IGNORE;
                        end
                    end
                    ST_PTR:
                    begin
                        o_sda_oe_n <= 1'b0;
                        state_r    <= ST_DATA_HI;
                        if (shift_r == `PTR_BURST)
                        begin
                            burst_r <= 1'b1;
                            ptr_r   <= 8'h00;
                        end
                        else
                        begin
                            ptr_r <= shift_r;
                        end
                    end
                    ST_DATA_HI:
                    begin
                        o_sda_oe_n <= 1'b0;
                        hi_r       <= shift_r;
                        state_r    <= ST_DATA_LO;
                    end
                    ST_DATA_LO:
                    begin
                        o_sda_oe_n <= 1'b0;
                        commit_r   <= 1'b1;
                        cmd_ptr_r  <= ptr_r;
                        cmd_rsel_r <= hi_r[7:6];
                        cmd_word_r <= {hi_r[5:0], shift_r};
                        if (burst_r && ptr_r[3:0] != `LAST_CH)
                        begin
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= ST_DATA_HI;
                        end
                        else
                        begin
                            burst_r <= 1'b0;
                            state_r <= ST_PTR;
                        end
                    end
                    default:
                    begin
                        o_sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // =================================================================
    // command decode
    function automatic logic is_cmd(input logic [1:0] rsel,
                                    input logic [7:0] ptr,
                                    input logic [5:0] code);
        is_cmd = rsel == `RSEL_SFR && ptr[5:0] == code;
    endfunction

    logic go_null;
    logic go_code;
    logic go_sclr;
    logic go_pd;
    logic go_pu;
    logic go_mon;
    logic go_ctrl;
    logic go_srst;
    logic go_chan;
    logic go_clear;
    logic [3:0] ch;

    assign ch       = cmd_ptr_r[3:0];
    assign go_null  = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_NULL);
    assign go_code  = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_CLR_CODE);
    assign go_sclr  = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_SOFT_CLR);
    assign go_pd    = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_PWR_DOWN);
    assign go_pu    = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_PWR_UP);
    assign go_mon   = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_MONITOR);
    assign go_ctrl  = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_CTRL);
    assign go_srst  = commit_r && is_cmd(cmd_rsel_r, cmd_ptr_r, `CMD_SOFT_RST);
    // the eight channel part refuses a pointer with the top select bit set
    assign go_chan  = commit_r && cmd_rsel_r != `RSEL_SFR &&
                      !(`EIGHT_CH_VAR && cmd_ptr_r[`CH_A3_BIT]);
    assign go_clear = go_sclr || (clr_d && !clr_s);

    // =================================================================
    // channel registers
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || go_srst)
        begin
            o_dac_code   <= {16{`DATA_RST}};
            o_gain       <= {16{`GAIN_RST}};
            o_offset     <= {16{`OFFS_RST}};
            o_clear_code <= `DATA_RST;
        end
        else if (go_clear)
        begin
            o_dac_code <= {16{o_clear_code}};
        end
        else if (go_chan)
        begin
            case (cmd_rsel_r)
                `RSEL_GAIN: o_gain[ch]     <= cmd_word_r;
                `RSEL_OFFS: o_offset[ch]   <= cmd_word_r;
                default:    o_dac_code[ch] <= cmd_word_r;
            endcase
        end
        else if (go_code)
        begin
            o_clear_code <= cmd_word_r;
        end
    end

    // =================================================================
    // busy timer; clear, null and soft reset pull busy low
    logic [11:0] busy_cnt_r;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            busy_cnt_r <= 12'h000;
        end
        else if (go_srst)
        begin
            busy_cnt_r <= 12'(`SOFT_RST_CYC);
        end
        else if (go_clear)
        begin
            busy_cnt_r <= `EIGHT_CH_VAR ? 12'(`CLR_CYC_8) : 12'(`CLR_CYC_16);
        end
        else if (go_null && busy_cnt_r == 12'h000)
        begin
            busy_cnt_r <= 12'h001;
        end
        else if (busy_cnt_r != 12'h000)
        begin
            busy_cnt_r <= busy_cnt_r - 12'h001;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_busy_n <= 1'b1;
        end
        else
        begin
            o_busy_n <= busy_cnt_r == 12'h000;
        end
    end

    // =================================================================
    // special function state: power, control, monitor
    logic        sw_pd_r;
    logic [7:0]  pu_cnt_r;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || go_srst)
        begin
            sw_pd_r    <= 1'b0;
            o_ctrl_reg <= `CTRL_RST;
            o_mon_sel  <= `MON_HIZ_SEL;
        end
        else
        begin
            if (go_pd)
            begin
                sw_pd_r <= 1'b1;
            end
            else if (go_pu)
            begin
                sw_pd_r <= 1'b0;
            end
            if (go_ctrl)
            begin
                o_ctrl_reg <= cmd_word_r;
            end
            if (go_mon)
            begin
                o_mon_sel <= cmd_word_r[`MON_SEL_HI:`MON_SEL_LO];
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_pwr_down     <= 1'b0;
            o_amp_hiz      <= 1'b0;
            o_amp_gnd_load <= 1'b0;
            o_amp_ready    <= 1'b0;
            pu_cnt_r       <= 8'(`PWR_UP_CYC);
            o_mon_hiz      <= 1'b1;
            o_mon_route_en <= 1'b0;
            o_toggle_allow <= 1'b1;
        end
        else
        begin
            o_pwr_down     <= pd_s || sw_pd_r;
            o_amp_hiz      <= o_pwr_down && o_ctrl_reg[`CR_PD_HIZ_BIT];
            o_amp_gnd_load <= o_pwr_down && !o_ctrl_reg[`CR_PD_HIZ_BIT];
            // references settle for the full window after any power-down
            if (o_pwr_down)
            begin
                pu_cnt_r <= 8'(`PWR_UP_CYC);
            end
            else if (pu_cnt_r != 8'h00)
            begin
                pu_cnt_r <= pu_cnt_r - 8'h01;
            end
            o_amp_ready    <= !o_pwr_down && pu_cnt_r == 8'h00;
            o_mon_hiz      <= o_mon_sel == `MON_HIZ_SEL;
            o_mon_route_en <= o_ctrl_reg[`CR_MON_EN_BIT] &&
                              o_mon_sel != `MON_HIZ_SEL;
            o_toggle_allow <= !burst_r;
        end
    end

    // =================================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_addr_ack_match: assert property (
        byte_done && state_r == ST_ADDR && shift_r == {`TGT_ADDR_HI, strap_d, 1'b0}
        |=> !o_sda_oe_n && state_r == ST_PTR)
        else $error("matching address not acknowledged");
    a_read_no_ack: assert property (
        byte_done && state_r == ST_ADDR && shift_r[0]
        |=> o_sda_oe_n && state_r == ST_IGNORE)
        else $error("read address was acknowledged");
    a_stop_ends_seq: assert property (
        stop_det |=> state_r == ST_IDLE && !burst_r && o_sda_oe_n)
        else $error("stop did not end the sequence");
    a_burst_start: assert property (
        byte_done && state_r == ST_PTR && shift_r == `PTR_BURST
        |=> burst_r && ptr_r == 8'h00 ##1 !o_toggle_allow)
        else $error("burst did not start at channel zero");
    a_partial_drop: assert property (
        state_r == ST_DATA_LO && stop_det |=> !commit_r ##1 !commit_r)
        else $error("partial word was committed");
    a_soft_clr_busy: assert property (
        go_sclr && busy_cnt_r == 12'h000 |-> ##2 (!o_busy_n) [*8])
        else $error("busy not held during soft clear");
    a_null_busy: assert property (
        go_null && busy_cnt_r == 12'h000 |-> ##2 !o_busy_n ##1 o_busy_n)
        else $error("null command busy pulse wrong");
    a_pd_or: assert property (
        pd_s || sw_pd_r |=> o_pwr_down ##1 !o_amp_ready)
        else $error("power-down not the or of both sources");
    a_pwrup_time: assert property (
        go_pu && !pd_s |-> ##[1:PWRUP_BOUND] o_amp_ready)
        else $error("power-up exceeded its window");
    a_srst_default: assert property (
        go_srst |=> o_gain[0] == `GAIN_RST && o_dac_code[15] == `DATA_RST &&
                    o_offset[0] == `OFFS_RST && o_ctrl_reg == `CTRL_RST)
        else $error("soft reset left a register off default");
    a_mon_gate: assert property (
        o_mon_route_en |-> $past(o_ctrl_reg[`CR_MON_EN_BIT]))
        else $error("monitor routed without enable");
endmodule // dac_i2c_target
`default_nettype wire

// *** core/line_sync.sv ***
// two flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_rst_val,
    output var  logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // resets to the idle level of each pin so no false edge appears
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            meta_r <= i_rst_val;
            o_sync <= i_rst_val;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // line_sync
`default_nettype wire

// *** verification/dac_i2c_write_and_sfr_decoder_tb.sv ***
// self-checking bench for the dac i2c write target and command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module dac_i2c_write_and_sfr_decoder_tb
    import dac_i2c_pkg::*;
;
// =====================================================================
// signals and instances
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       clear_n = 1'b1;
    logic       hw_pd = 1'b0;
    logic       scl, m_sda, sda_line, sda_out, sda_oe_n, busy_n;
    logic       pwr_down, amp_hiz, amp_gnd, amp_ready, mon_hiz, route_en, toggle_allow;
    logic [5:0] mon_sel;
    bank_t      dac_code, gain, offset;
    word_t      clear_code, ctrl_reg;
    int         errors = 0;
    int         checked = 0;
    int         cycles = 0;
    int         busy_cnt = 0;
    // open drain line with pull-up
    assign sda_line = m_sda & (sda_oe_n | sda_out);
    always #25 core_clk = ~core_clk;
    i2c_master_model master (.o_scl(scl), .o_sda(m_sda), .i_sda_line(sda_line));
    dac_i2c_target uut (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_line),
        .i_addr_strap_hi(1'b1), .i_addr_strap_lo(1'b0), .i_clear_n(clear_n),
        .i_hw_pwr_down(hw_pd), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .o_dac_code(dac_code), .o_gain(gain), .o_offset(offset),
        .o_clear_code(clear_code), .o_ctrl_reg(ctrl_reg), .o_busy_n(busy_n),
        .o_pwr_down(pwr_down), .o_amp_hiz(amp_hiz), .o_amp_gnd_load(amp_gnd),
        .o_amp_ready(amp_ready), .o_mon_sel(mon_sel), .o_mon_hiz(mon_hiz),
        .o_mon_route_en(route_en), .o_toggle_allow(toggle_allow));
// =====================================================================
// shared tasks
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (busy_n === 1'b0)
            busy_cnt++;
        if (cycles == 30000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic wb(input logic [7:0] b, input logic exp_ack);
        logic ack;
        master.put_byte(b, ack);
        `CHK(ack, exp_ack)
    endtask
    // one 4-byte frame, then a fixed settle time
    task automatic cmd(input logic [7:0] ptr, input logic [15:0] d, input int settle);
        busy_cnt = 0;
        master.start_bit();
        wb(8'hac, 1'b1);
        wb(ptr, 1'b1);
        wb(d[15:8], 1'b1);
        wb(d[7:0], 1'b1);
        master.stop_bit();
        repeat (settle) @(posedge core_clk);
        #1;
    endtask
// =====================================================================
// scenarios
    task automatic t_writes();
        `CHK(clear_code, 14'h0000)
        master.start_bit();
        wb(8'hac, 1'b1);
        wb(8'h03, 1'b1);
        wb(8'hc1, 1'b1);
        wb(8'h23, 1'b1);
        `CHK(dac_code[3], 14'h0123)
        wb(8'h05, 1'b1);
        wb(8'h8a, 1'b1);
        wb(8'hbc, 1'b1);
        wb(8'h07, 1'b1);
        wb(8'h40, 1'b1);
        wb(8'h11, 1'b1);
        wb(8'h09, 1'b1);
        wb(8'hff, 1'b1);
        master.stop_bit();
        `CHK(offset[5], 14'h0abc)
        `CHK(gain[7], 14'h0011)
        `CHK(dac_code[9], 14'h0000)
        master.start_bit();
        wb(8'ha8, 1'b0);
        wb(8'h06, 1'b0);
        wb(8'hc1, 1'b0);
        master.stop_bit();
        master.start_bit();
        wb(8'had, 1'b0);
        master.stop_bit();
        `CHK(dac_code[6], 14'h0000)
        $display("test writes done");
    endtask
    task automatic t_burst();
        master.start_bit();
        wb(8'hac, 1'b1);
        wb(8'hff, 1'b1);
        for (int c = 0; c < 16; c++)
        begin
            wb(8'hc0 | c[7:0], 1'b1);
            wb(8'h40 + c[7:0], 1'b1);
            if (c < 15)
                `CHK(toggle_allow, 1'b0)
        end
        for (int c = 0; c < 16; c++)
            `CHK(dac_code[c], {c[5:0], 8'h40 + c[7:0]})
        wb(8'h02, 1'b1);
        wb(8'hc0, 1'b1);
        wb(8'h77, 1'b1);
        `CHK(dac_code[2], 14'h0077)
        wb(8'hff, 1'b1);
        wb(8'hc0, 1'b1);
        wb(8'h55, 1'b1);
        master.stop_bit();
        `CHK(toggle_allow, 1'b1)
        cmd(8'h01, 16'hc001, 2);
        `CHK(dac_code[1], 14'h0001)
        `CHK(dac_code[0], 14'h0055)
        $display("test burst done");
    endtask
    task automatic t_cmds();
        cmd(8'h00, 16'h0000, 20);
        `CHK(busy_cnt, 1)
        `CHK(dac_code[2], 14'h0077)
        cmd(8'h01, 16'h0155, 5);
        `CHK(clear_code, 14'h0155)
        cmd(8'h02, 16'h0000, 450);
        `CHK(busy_cnt, 400)
        `CHK(dac_code[11], 14'h0155)
        cmd(8'h01, 16'h0aaa, 5);
        busy_cnt = 0;
        clear_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 clear_n = 1'b1;
        repeat (450) @(posedge core_clk);
        #1;
        `CHK(busy_cnt, 400)
        `CHK(dac_code[0], 14'h0aaa)
        cmd(8'h08, 16'h0000, 5);
        `CHK(pwr_down, 1'b1)
        `CHK(amp_hiz, 1'b1)
        `CHK(dac_code[0], 14'h0aaa)
        cmd(8'h09, 16'h0000, 160);
        `CHK(amp_ready, 1'b1)
        cmd(8'h0a, 16'h0500, 5);
        `CHK(mon_sel, 6'h05)
        `CHK(route_en, 1'b0)
        cmd(8'h0c, 16'h0400, 5);
        `CHK(ctrl_reg, 14'h0400)
        `CHK(route_en, 1'b1)
        cmd(8'h0a, 16'h2500, 5);
        `CHK(mon_sel, 6'h25)
        cmd(8'h0a, 16'h3f00, 5);
        `CHK({mon_hiz, route_en}, 2'h2)
        hw_pd = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        `CHK({pwr_down, amp_gnd, amp_hiz}, 3'h6)
        hw_pd = 1'b0;
        cmd(8'h0f, 16'h0000, 2750);
        `CHK(busy_cnt, 2700)
        `CHK(pwr_down, 1'b0)
        `CHK({gain[7], offset[5], dac_code[3]}, {14'h3fff, 28'h0})
        `CHK({clear_code, ctrl_reg}, {14'h0000, 14'h2000})
        $display("test commands done");
    endtask
// =====================================================================
// main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        t_writes();
        t_burst();
        t_cmds();
        end_of_test();
    end
endmodule // dac_i2c_write_and_sfr_decoder_tb
`default_nettype wire

// *** verification/i2c_master_model.sv ***
// bus master model driving scl and sda of the dac i2c target
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// i2c master, scl idles high outside frames
module i2c_master_model
(
    output var  logic o_scl,
    output var  logic o_sda,
    input  wire logic i_sda_line
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // also a repeated start, since scl is low between bytes
    task automatic start_bit();
        #100 o_sda = 1'b1;
        #100 o_scl = 1'b1;
        #100 o_sda = 1'b0;
        #100 o_scl = 1'b0;
    endtask
    task automatic stop_bit();
        #100 o_sda = 1'b0;
        #100 o_scl = 1'b1;
        #100 o_sda = 1'b1;
        // bus free time long enough for the target to see the stop and settle
        #400;
    endtask
    // data moves late in the low phase so the ack release never looks like a stop
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #150 o_sda = b[i];
            #100 o_scl = 1'b1;
            #150 o_scl = 1'b0;
        end
        #100 o_sda = 1'b1;
        #150 o_scl = 1'b1;
        #150 ack = ~i_sda_line;
        o_scl = 1'b0;
    endtask
endmodule // i2c_master_model
`default_nettype wire
